// ===== design/jid_tap.sv
`timescale 1ns/1ns
// Overview of operation
// RULE_01: SAMPLE/PRELOAD captures pin levels into boundary cells.
// RULE_02: SAMPLE/PRELOAD takes a shifted pattern for later output use.
// RULE_03: EXTEST drives boundary data on outputs, captures input levels.
// RULE_04: All-ones BYPASS puts one-bit register between TDI and TDO.
// RULE_05: USERCODE puts the 32-bit user code register between TDI and TDO.
// RULE_06: Without a given user code, every user code bit reads one.
// RULE_07: Tester waits for supplies and configuration time before scanning.
// RULE_08: Test access logic runs once core supply is up, regardless of banks.
// RULE_09: Tester holds test clock low during power-up.
// RULE_10: Instruction register is ten bits; tester shifts ten per scan.
// RULE_11: Tester never loads unsupported instruction codes.
// RULE_12: TAP sequencing follows the boundary-scan standard, TMS on TCK rise.
// RULE_13: Test-Logic-Reset selects bypass so normal pin operation continues.
module jid_tap
   import jid_pkg::*;
#(
   parameter int BSR_LEN = BSR_LEN_DEF,
   parameter logic [UC_LEN-1:0] USERCODE = UC_DEFAULT // [RULE_06]
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CORE_SUPPLY_OK,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE,
   input wire logic [BSR_LEN-1:0] PIN_IN,
   input wire logic [BSR_LEN-1:0] CORE_OUT,
   output logic [BSR_LEN-1:0] PIN_OUT
);

   generate
      if (BSR_LEN < 2) begin : g_chk
         $error("BSR_LEN must be at least 2");
      end
   endgenerate

   // Two-stage synchronisers; tck gets a third stage for edge finding
   logic tck_m_q, tck_s_q, tck_p_q;
   logic tms_m_q, tms_s_q, tdi_m_q, tdi_s_q, core_m_q, core_s_q;
   logic [BSR_LEN-1:0] pin_m_q, pin_s_q;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         tck_m_q <= 1'b0;
         tck_s_q <= 1'b0;
         tck_p_q <= 1'b0;
         tms_m_q <= 1'b1;
         tms_s_q <= 1'b1;
         tdi_m_q <= 1'b0;
         tdi_s_q <= 1'b0;
         core_m_q <= 1'b0;
         core_s_q <= 1'b0;
         pin_m_q <= '0;
         pin_s_q <= '0;
      end else begin
         tck_m_q <= TCK;
         tck_s_q <= tck_m_q;
         tck_p_q <= tck_s_q;
         tms_m_q <= TMS;
         tms_s_q <= tms_m_q;
         tdi_m_q <= TDI;
         tdi_s_q <= tdi_m_q;
         core_m_q <= CORE_SUPPLY_OK;
         core_s_q <= core_m_q;
         pin_m_q <= PIN_IN;
         pin_s_q <= pin_m_q;
      end
   end

   logic rise, fall;
   assign rise = tck_s_q & ~tck_p_q;
   assign fall = ~tck_s_q & tck_p_q;

   jid_tap_e state_q, state_d;
   logic [IR_LEN-1:0] ir_q, ir_d, instr_q, instr_d;
   logic [UC_LEN-1:0] user_q, user_d;
   logic [BSR_LEN-1:0] bsr_q, bsr_d, upd_q, upd_d, pin_out_d;
   logic bypass_q, bypass_d, tdo_d, tdo_oe_d;
   logic is_bsr, is_user;

   function automatic jid_tap_e tap_next(jid_tap_e s, logic tms);
      case (s)
         TLR: tap_next = tms ? TLR : RTI;
         RTI: tap_next = tms ? SEL_DR : RTI;
         SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
         CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
         SH_DR: tap_next = tms ? EX1_DR : SH_DR;
         EX1_DR: tap_next = tms ? UPD_DR : PA_DR;
         PA_DR: tap_next = tms ? EX2_DR : PA_DR;
         EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
         UPD_DR: tap_next = tms ? SEL_DR : RTI;
         SEL_IR: tap_next = tms ? TLR : CAP_IR;
         CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
         SH_IR: tap_next = tms ? EX1_IR : SH_IR;
         EX1_IR: tap_next = tms ? UPD_IR : PA_IR;
         PA_IR: tap_next = tms ? EX2_IR : PA_IR;
         EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
         UPD_IR: tap_next = tms ? SEL_DR : RTI;
         default: tap_next = TLR;
      endcase
   endfunction

   // Unknown codes fall through to bypass, the safest routing
   assign is_bsr = (instr_q == INS_SAMPLE) || (instr_q == INS_EXTEST);
   assign is_user = (instr_q == INS_USERCODE);

   always_comb begin
      state_d = state_q;
      ir_d = ir_q;
      instr_d = instr_q;
      user_d = user_q;
      bsr_d = bsr_q;
      upd_d = upd_q;
      bypass_d = bypass_q;
      tdo_d = TDO;
      tdo_oe_d = TDO_OE;
      if (!core_s_q) begin
         // Held only by core supply; bank supplies play no part [RULE_08]
         state_d = TLR;
         instr_d = INS_BYPASS; // [RULE_13]
      end else if (rise) begin
         state_d = tap_next(state_q, tms_s_q); // [RULE_12]
         case (state_q)
            TLR: begin
               instr_d = INS_BYPASS; // [RULE_13]
            end
            CAP_IR: begin
               ir_d = IR_CAPTURE; // [RULE_10]
            end
            SH_IR: begin
               ir_d = {tdi_s_q, ir_q[IR_LEN-1:1]}; // [RULE_10]
            end
            CAP_DR: begin
               if (is_bsr) begin
                  bsr_d = pin_s_q; // [RULE_01] [RULE_03]
               end else if (is_user) begin
                  user_d = USERCODE; // [RULE_05]
               end else begin
                  bypass_d = 1'b0; // [RULE_04]
               end
            end
            SH_DR: begin
               if (is_bsr) begin
                  bsr_d = {tdi_s_q, bsr_q[BSR_LEN-1:1]}; // [RULE_02]
               end else if (is_user) begin
                  user_d = {tdi_s_q, user_q[UC_LEN-1:1]}; // [RULE_05]
               end else begin
                  bypass_d = tdi_s_q; // [RULE_04]
               end
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         // Output side changes on the falling test clock edge [RULE_12]
         tdo_oe_d = (state_q == SH_IR) || (state_q == SH_DR);
         if (state_q == SH_IR) begin
            tdo_d = ir_q[0];
         end else if (state_q == SH_DR) begin
            tdo_d = is_bsr ? bsr_q[0] : (is_user ? user_q[0] : bypass_q);
         end
         if (state_q == UPD_IR) begin
            instr_d = ir_q; // [RULE_12]
         end
         if (state_q == UPD_DR && is_bsr) begin
            upd_d = bsr_q; // [RULE_02]
         end
      end
   end

   // Core keeps the pins unless EXTEST is current [RULE_03]
   assign pin_out_d = (instr_q == INS_EXTEST) ? upd_q : CORE_OUT;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_q <= TLR;
         ir_q <= IR_CAPTURE;
         instr_q <= INS_BYPASS;
         user_q <= UC_DEFAULT;
         bsr_q <= '0;
         upd_q <= '0;
         bypass_q <= 1'b0;
         TDO <= 1'b0;
         TDO_OE <= 1'b0;
         PIN_OUT <= '0;
      end else begin
         state_q <= state_d;
         ir_q <= ir_d;
         instr_q <= instr_d;
         user_q <= user_d;
         bsr_q <= bsr_d;
         upd_q <= upd_d;
         bypass_q <= bypass_d;
         TDO <= tdo_d;
         TDO_OE <= tdo_oe_d;
         PIN_OUT <= pin_out_d;
      end
   end

   sequence s_cap_user;
      rise && state_q == CAP_DR && is_user && core_s_q;
   endsequence

   sequence s_cap_bsr;
      rise && state_q == CAP_DR && is_bsr && core_s_q;
   endsequence

   a_tlr_bypass: assert property (@(posedge CLK) // [RULE_13]
      disable iff (RESET) rise && state_q == TLR |=> instr_q == INS_BYPASS)
      else $error("Reset state did not select bypass");

   a_core_hold: assert property (@(posedge CLK) // [RULE_08]
      disable iff (RESET) !core_s_q |=> state_q == TLR)
      else $error("TAP ran without core supply");

   a_ir_capture: assert property (@(posedge CLK) // [RULE_10]
      disable iff (RESET)
      rise && state_q == CAP_IR && core_s_q |=> ir_q == IR_CAPTURE)
      else $error("Instruction capture pattern wrong");

   a_bypass_delay: assert property (@(posedge CLK) // [RULE_04]
      disable iff (RESET)
      rise && state_q == SH_DR && !is_bsr && !is_user && core_s_q
      |=> bypass_q == $past(tdi_s_q))
      else $error("Bypass stage did not take TDI");

   a_usercode_load: assert property (@(posedge CLK) // [RULE_05]
      disable iff (RESET) s_cap_user |=> user_q == USERCODE)
      else $error("User code not loaded at capture");

   a_pin_capture: assert property (@(posedge CLK) // [RULE_01]
      disable iff (RESET) s_cap_bsr |=> bsr_q == $past(pin_s_q))
      else $error("Boundary cells missed pin snapshot");

   a_extest_drive: assert property (@(posedge CLK) // [RULE_03]
      disable iff (RESET)
      instr_q == INS_EXTEST |=> PIN_OUT == $past(upd_q))
      else $error("EXTEST not driving boundary data");

   a_normal_pins: assert property (@(posedge CLK) // [RULE_01]
      disable iff (RESET)
      instr_q != INS_EXTEST |=> PIN_OUT == $past(CORE_OUT))
      else $error("Pins disturbed outside EXTEST");

   a_preload_update: assert property (@(posedge CLK) // [RULE_02]
      disable iff (RESET)
      fall && state_q == UPD_DR && is_bsr && core_s_q
      |=> upd_q == $past(bsr_q))
      else $error("Preload pattern not latched");

   a_tdo_shift: assert property (@(posedge CLK) // [RULE_12]
      disable iff (RESET)
      fall && state_q == SH_IR && core_s_q
      |=> TDO == $past(ir_q[0]) && TDO_OE)
      else $error("TDO wrong during instruction shift");

   // Driver must be off outside both shift states
   a_oe_idle: assert property (@(posedge CLK) // [RULE_12]
      disable iff (RESET)
      fall && state_q != SH_IR && state_q != SH_DR && core_s_q
      |=> !TDO_OE)
      else $error("TDO driven outside a shift state");

endmodule // jid_tap

// ===== include/jid_pkg.sv
package jid_pkg;
   localparam int IR_LEN = 10;
   localparam int UC_LEN = 32;
   localparam int BSR_LEN_DEF = 240;
   localparam logic [IR_LEN-1:0] INS_SAMPLE = 10'h005;
   localparam logic [IR_LEN-1:0] INS_EXTEST = 10'h00F;
   localparam logic [IR_LEN-1:0] INS_BYPASS = 10'h3FF;
   localparam logic [IR_LEN-1:0] INS_USERCODE = 10'h007;
   // Fixed pattern loaded in Capture-IR, low bits 01
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
   // Value held when the design gives no user code
   localparam logic [UC_LEN-1:0] UC_DEFAULT = 32'hFFFFFFFF;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } jid_tap_e;
endpackage

// ===== sim/jid_tester.sv
`timescale 1ns/1ns
module jid_tester (
   input wire logic CLK,
   input wire logic TDO,
   input wire logic TDO_OE,
   output logic TCK,
   output logic TMS,
   output logic TDI
);
   logic oe_ok;
   logic oe;
   initial begin
      TCK = 1'b0; // Held low until the first frame
      TMS = 1'b1;
      TDI = 1'b0;
      oe_ok = 1'b1;
   end
   // One period: 4 CLK low, 4 CLK high
   task automatic tick(input logic ms, input logic di, output logic dq);
      TMS = ms;
      TDI = di;
      repeat (4) @(posedge CLK);
      #1 TCK = 1'b1;
      dq = TDO;
      oe = TDO_OE;
      repeat (4) @(posedge CLK);
      #1 TCK = 1'b0;
   endtask
   task automatic reset_tap();
      logic d;
      repeat (5) tick(1'b1, ~TDI, d);
      tick(1'b0, ~TDI, d);
   endtask
   // From idle through one scan back to idle; TDI toggles when unused
   task automatic scan(input logic ir, input int n, input logic [63:0] di,
                       output logic [63:0] dq);
      logic d;
      dq = '0;
      oe_ok = 1'b1;
      tick(1'b1, ~TDI, d);
      if (ir) tick(1'b1, ~TDI, d);
      tick(1'b0, ~TDI, d);
      tick(1'b0, ~TDI, d);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, di[i], dq[i]); // Exactly n bits
         if (oe !== 1'b1) oe_ok = 1'b0;
      end
      tick(1'b1, ~TDI, d);
      tick(1'b0, ~TDI, d);
   endtask
endmodule // jid_tester

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
   import jid_pkg::*;
   localparam int BL = 8;
   logic clk, reset, sup_ok, tck, tms, tdi, tdo, tdo_oe;
   logic [BL-1:0] pin_in, core_out, pin_out;
   logic [63:0] so, pat;
   int mismatches, cmp_count;
   jid_tap #(.BSR_LEN(BL)) jid_tap_inst (.CLK(clk), .RESET(reset),
      .CORE_SUPPLY_OK(sup_ok), .TCK(tck), .TMS(tms), .TDI(tdi),
      .TDO(tdo), .TDO_OE(tdo_oe), .PIN_IN(pin_in),
      .CORE_OUT(core_out), .PIN_OUT(pin_out));
   jid_tester jid_tester_inst (.CLK(clk), .TDO(tdo), .TDO_OE(tdo_oe),
      .TCK(tck), .TMS(tms), .TDI(tdi));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk_scan(input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected scan at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_pin(input logic [BL-1:0] e, input logic [BL-1:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected pins at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bypass captures 0, then TDI one stage late
   function automatic logic [63:0] byp(input logic [63:0] d, input int n);
      return {d[62:0], 1'b0} & ((64'h1 << n) - 64'h1);
   endfunction
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic load(input logic [IR_LEN-1:0] ins);
      jid_tester_inst.scan(1'b1, IR_LEN, 64'(ins), so);
      chk_scan(64'(IR_CAPTURE), so);
   endtask
   task automatic byp_test();
      pat = {$urandom, $urandom};
      jid_tester_inst.scan(1'b0, 20, pat, so);
      chk_scan(byp(pat, 20), so);
      chk_scan(64'h1, 64'(jid_tester_inst.oe_ok));
      chk_scan(64'h0, 64'(tdo_oe));
   endtask
   initial begin
      void'($urandom(26063));
      reset = 1'b1;
      sup_ok = 1'b1;
      pin_in = '0;
      core_out = '0;
      mismatches = 0;
      cmp_count = 0;
      wait_clk(6);
      reset = 1'b0;
      wait_clk(4);
      jid_tester_inst.reset_tap();
      byp_test();
      $display("test default_bypass done");
      load(INS_USERCODE);
      jid_tester_inst.scan(1'b0, UC_LEN, pat, so);
      chk_scan(64'(UC_DEFAULT), so);
      load(INS_BYPASS);
      byp_test();
      $display("test usercode_bypass done");
      for (int r = 0; r < 3; r++) begin
         pin_in = BL'($urandom);
         core_out = BL'($urandom);
         pat = 64'(BL'($urandom));
         load(INS_SAMPLE);
         jid_tester_inst.scan(1'b0, BL, pat, so);
         chk_scan(64'(pin_in), so);
         chk_pin(core_out, pin_out);
         load(INS_EXTEST);
         wait_clk(6);
         chk_pin(pat[BL-1:0], pin_out);
         core_out = ~core_out;
         pin_in = BL'($urandom);
         jid_tester_inst.scan(1'b0, BL, ~pat, so);
         chk_scan(64'(pin_in), so);
         wait_clk(6);
         chk_pin(~pat[BL-1:0], pin_out);
      end
      $display("test sample_extest done");
      sup_ok = 1'b0;
      wait_clk(6);
      chk_pin(core_out, pin_out);
      sup_ok = 1'b1;
      wait_clk(4);
      jid_tester_inst.reset_tap();
      byp_test();
      $display("test supply_drop done");
      conclude();
   end
   initial begin
      #3000000;
      mismatches++;
      conclude();
   end
endmodule // tb
